// file: logic/hsh_homing.sv
`timescale 1ns/10ps
// What this block does
// RULE1 - Rising start request begins the set chosen at power stage enable
// RULE2 - Motion-done flag clears when a data set starts
// RULE3 - Homing set ends, next set starts with no further condition
// RULE4 - Blended transition moves on without waiting for standstill
// RULE5 - After wait time, move on at once if condition already holds
// RULE6 - After last set, wait for a new rising start request
// RULE7 - Sequence completion drives motion-done flag to one; the code does not raise it when the last set's successor is the starting set
// RULE8 - New start after completion runs the last set's successor
// RULE9 - Motion-done flag only rises while start request is low
// RULE10 - Homing accepted only in fieldbus control mode
// RULE11 - Homing parameter writes take effect on receipt
// RULE12 - Completed homing sets the reference point as zero plus offset
// RULE13 - Interrupted homing invalidates reference; mode change refused meanwhile
// RULE14 - Set dimensions loads position with requested value, no motion
// RULE15 - Index methods stop on index pulse; others after a distance
// RULE16 - Control word bit 4 written to one starts homing
// RULE17 - Status bit 10 shows homing finished, also after halt
// RULE18 - Status bit 12 set only on successful homing
// RULE19 - Bit 13 flags errors; bit 14 homing done and standstill
// RULE20 - Status bit 15 shows a valid reference point
// RULE21 - Method code decode per table, default 18
// RULE22 - Limit inputs evaluated only when enabled, with chosen level
// RULE23 - Home switch always evaluated with its configured level
// RULE24 - Integrator should prefer active-low monitoring signals
// RULE25 - Motion-done stays low through the sequence until final completion
module hsh_homing
  import hsh_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire hsh_wr_t reg_wr,
  input wire logic [15:0] reg_addr,
  output logic [15:0] reg_rdata_ff,
  input wire logic fieldbus_mode,
  input wire logic power_enable,
  input wire logic sequence_start_request,
  input wire logic [3:0] starting_set_number,
  input wire logic set_wr,
  input wire logic [3:0] set_waddr,
  input wire hsh_set_t set_wdata,
  input wire logic motion_done,
  input wire logic standstill,
  input wire logic halt,
  input wire logic abort,
  input wire logic dist_reached,
  input wire logic index_pulse,
  input wire logic negative_limit_switch,
  input wire logic positive_limit_switch,
  input wire logic home_switch,
  input wire logic mode_change_req,
  input wire logic [31:0] setdim_value,
  output logic [15:0] drive_status_word_ff,
  output logic move_start_ff,
  output logic [3:0] move_set_ff,
  output logic home_dir_pos_ff,
  output logic home_move_ff,
  output logic pos_load_ff,
  output logic [31:0] pos_load_value_ff,
  output logic mode_change_ok_ff,
  output logic x_end_ff
);
  logic [15:0] homing_method_select_ff;
  logic [1:0] positive_limit_polarity_ff;
  logic [1:0] negative_limit_polarity_ff;
  logic [1:0] home_switch_polarity_ff;
  logic [31:0] home_pos_ff;
  logic ref_ok_ff, attained_ff, err_ff, target_ff, home_busy;
  logic start_d_ff, start_rise, pe_d_ff;
  logic [3:0] cur_set_ff, nxt_set;
  logic [7:0] wait_ff;
  hsh_home_t home_ff;
  hsh_seq_t seq_ff;
  hsh_set_t set_rd, fin_set_ff;
  logic home_cmd, lim_n, lim_p, ref_sw, sw_hit;

  // Active level of a switch from its polarity code; off reads inactive
  function automatic logic sw_active(input logic [1:0] pol,
                                     input logic pin);
    sw_active = (pol == HSH_POL_NC) ? ~pin :
                (pol == HSH_POL_NO) ? pin : 1'b0;
  endfunction : sw_active

  // Method code decode helpers
  function automatic logic m_index(input logic [7:0] m);
    m_index = (m >= HSH_M_IDX_LO && m <= HSH_M_IDX_HI) ||
              (m == HSH_M_IDXNEG);
  endfunction : m_index

  function automatic logic m_valid(input logic [7:0] m);
    m_valid = m_index(m) || m == HSH_M_NEGATIVE_LIMIT_SWITCH || m == HSH_M_POSITIVE_LIMIT_SWITCH ||
              (m >= HSH_M_REF_LO && m <= HSH_M_REF_HI) ||
              m == HSH_M_SETDIM;
  endfunction : m_valid

  hsh_set_mem u_mem (
    .clk(clk),
    .ce(ce),
    .wr(set_wr),
    .waddr(set_waddr),
    .wdata(set_wdata),
    .raddr(nxt_set),
    .rdata(set_rd)
  );

  // Switch evaluation; limits gated by their enable, home switch never
  assign lim_n = sw_active(negative_limit_polarity_ff,
                           negative_limit_switch); // [RULE22]
  assign lim_p = sw_active(positive_limit_polarity_ff,
                           positive_limit_switch); // [RULE22]
  // Home switch code 0 is treated as active low, so it is always live
  assign ref_sw = (home_switch_polarity_ff == HSH_POL_NO) ?
                  home_switch : ~home_switch; // [RULE23]
  always_comb begin
    sw_hit = 1'b0;
    if (homing_method_select_ff[7:0] == HSH_M_NEGATIVE_LIMIT_SWITCH ||
        homing_method_select_ff[7:0] == HSH_M_IDX_LO) begin
      sw_hit = lim_n;
    end else if (homing_method_select_ff[7:0] == HSH_M_POSITIVE_LIMIT_SWITCH ||
                 homing_method_select_ff[7:0] == 8'h02) begin
      sw_hit = lim_p;
    end else if (homing_method_select_ff[7:0] == HSH_M_IDXNEG) begin
      sw_hit = 1'b1;
    end else begin
      sw_hit = ref_sw;
    end
  end

  // Control word bit 4 written to one, in fieldbus mode only
  assign home_cmd = reg_wr.wr && reg_wr.addr == HSH_ADDR_CTRL &&
                    reg_wr.data[HSH_CTRL_HOME_BIT] &&
                    fieldbus_mode; // [RULE16] [RULE10]
  assign home_busy = (home_ff == HSH_SEARCH) ||
                     (home_ff == HSH_APPROACH);

  // Parameter registers update on the write itself, no commit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      homing_method_select_ff <= HSH_METHOD_RST; // [RULE21]
      positive_limit_polarity_ff <= HSH_POL_RST_LIM;
      negative_limit_polarity_ff <= HSH_POL_RST_LIM;
      home_switch_polarity_ff <= HSH_POL_RST_REF;
      home_pos_ff <= 32'h0000_0000;
    end else if (ce && reg_wr.wr) begin
      if (reg_wr.addr == HSH_ADDR_METHOD) begin
        homing_method_select_ff <= reg_wr.data; // [RULE11]
      end else if (reg_wr.addr == HSH_ADDR_HOMEPOS_LO) begin
        home_pos_ff[15:0] <= reg_wr.data;
      end else if (reg_wr.addr == HSH_ADDR_HOMEPOS_HI) begin
        home_pos_ff[31:16] <= reg_wr.data;
      end else if (reg_wr.addr == HSH_ADDR_POL) begin
        negative_limit_polarity_ff <= reg_wr.data[1:0];
        positive_limit_polarity_ff <= reg_wr.data[3:2];
        home_switch_polarity_ff <= reg_wr.data[5:4];
      end
    end
  end

  // Homing state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      home_ff <= HSH_IDLE;
      ref_ok_ff <= 1'b0;
      attained_ff <= 1'b0;
      err_ff <= 1'b0;
      target_ff <= 1'b0;
      home_move_ff <= 1'b0;
      home_dir_pos_ff <= 1'b0;
      pos_load_ff <= 1'b0;
      pos_load_value_ff <= 32'h0000_0000;
    end else if (ce) begin
      pos_load_ff <= 1'b0;
      case (home_ff)
        HSH_IDLE, HSH_DONE, HSH_FAIL: begin
          if (home_cmd) begin
            attained_ff <= 1'b0;
            target_ff <= 1'b0;
            err_ff <= 1'b0;
            if (!m_valid(homing_method_select_ff[7:0])) begin
              err_ff <= 1'b1;
              target_ff <= 1'b1;
              home_ff <= HSH_FAIL;
            end else if (homing_method_select_ff[7:0] == HSH_M_SETDIM)
            begin
              home_ff <= HSH_SETDIM;
            end else begin
              ref_ok_ff <= 1'b0;
              home_move_ff <= 1'b1;
              home_dir_pos_ff <=
                homing_method_select_ff[7:0] == HSH_M_POSITIVE_LIMIT_SWITCH;
              home_ff <= HSH_SEARCH;
            end
          end
        end
        HSH_SETDIM: begin
          pos_load_ff <= 1'b1; // [RULE14]
          pos_load_value_ff <= setdim_value;
          ref_ok_ff <= 1'b1;
          attained_ff <= 1'b1;
          target_ff <= 1'b1;
          home_ff <= HSH_DONE;
        end
        HSH_SEARCH, HSH_APPROACH: begin
          if (halt || abort) begin
            home_move_ff <= 1'b0;
            ref_ok_ff <= 1'b0; // [RULE13]
            err_ff <= abort;
            target_ff <= 1'b1; // [RULE17]
            home_ff <= HSH_FAIL;
          end else if (home_ff == HSH_SEARCH) begin
            if (sw_hit) begin
              home_ff <= HSH_APPROACH;
            end
          end else if (m_index(homing_method_select_ff[7:0]) ?
                       index_pulse : dist_reached) begin // [RULE15]
            home_move_ff <= 1'b0;
            pos_load_ff <= 1'b1;
            pos_load_value_ff <= home_pos_ff; // [RULE12]
            ref_ok_ff <= 1'b1; // [RULE20]
            attained_ff <= 1'b1; // [RULE18]
            target_ff <= 1'b1;
            home_ff <= HSH_DONE;
          end
        end
        default: begin
          home_ff <= HSH_IDLE;
        end
      endcase
    end
  end

  // Mode change allowed only when no reference movement is in progress
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_change_ok_ff <= 1'b0;
    end else if (ce) begin
      // A homing start in this cycle also refuses the change
      mode_change_ok_ff <= mode_change_req && !home_busy &&
                           !home_cmd; // [RULE13]
    end
  end

  // Start request edge and power stage enable edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_d_ff <= 1'b0;
      pe_d_ff <= 1'b0;
    end else if (ce) begin
      start_d_ff <= sequence_start_request;
      pe_d_ff <= power_enable;
    end
  end
  assign start_rise = sequence_start_request && !start_d_ff;

  // Memory read address follows the set about to run
  always_comb begin
    nxt_set = cur_set_ff;
    if (power_enable && !pe_d_ff) begin
      nxt_set = starting_set_number;
    end else if (seq_ff == HSH_S_RUN &&
                 (motion_done || set_rd.cond == HSH_TC_BLEND)) begin
      nxt_set = set_rd.next;
    end
  end

  // Sequence engine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_ff <= HSH_S_WAITSTART;
      cur_set_ff <= 4'h0;
      wait_ff <= 8'h00;
      fin_set_ff <= '0;
      move_start_ff <= 1'b0;
      move_set_ff <= 4'h0;
      x_end_ff <= 1'b0;
    end else if (ce) begin
      move_start_ff <= 1'b0;
      cur_set_ff <= nxt_set;
      if (!power_enable) begin
        seq_ff <= HSH_S_WAITSTART;
      end else begin
        case (seq_ff)
          HSH_S_WAITSTART: begin
            if (start_rise && fieldbus_mode) begin // [RULE1] [RULE8]
              move_start_ff <= 1'b1;
              move_set_ff <= cur_set_ff;
              x_end_ff <= 1'b0; // [RULE2]
              seq_ff <= HSH_S_RUN;
            end else if (!sequence_start_request && standstill &&
                         !x_end_ff && start_d_ff == 1'b0 &&
                         cur_set_ff != starting_set_number) begin
              x_end_ff <= 1'b1; // [RULE7] [RULE9]
            end
          end
          HSH_S_RUN: begin
            x_end_ff <= 1'b0; // [RULE25]
            if (motion_done || (set_rd.cond == HSH_TC_BLEND)) begin
              wait_ff <= set_rd.wait_ticks;
              fin_set_ff <= set_rd; // Exit rule of the set just ended
              seq_ff <= HSH_S_DELAY; // [RULE4]
            end
          end
          HSH_S_DELAY: begin
            if (wait_ff != 8'h00) begin
              wait_ff <= wait_ff - 8'h01;
            end else begin
              seq_ff <= HSH_S_TRANS;
            end
          end
          HSH_S_TRANS: begin
            if (fin_set_ff.last && !fin_set_ff.homing) begin
              seq_ff <= HSH_S_WAITSTART; // [RULE6]
            end else if (fin_set_ff.homing ||
                         fin_set_ff.cond != HSH_TC_EDGE &&
                         (fin_set_ff.cond != HSH_TC_LEVEL ||
                          sequence_start_request)) begin
              move_start_ff <= 1'b1; // [RULE3] [RULE5]
              move_set_ff <= cur_set_ff;
              seq_ff <= HSH_S_RUN;
            end else if (start_rise) begin
              move_start_ff <= 1'b1;
              move_set_ff <= cur_set_ff;
              seq_ff <= HSH_S_RUN;
            end
          end
          default: begin
            seq_ff <= HSH_S_WAITSTART;
          end
        endcase
      end
    end
  end

  // Status word: bits 10, 12 to 15
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_status_word_ff <= 16'h0000;
    end else if (ce) begin
      drive_status_word_ff <= 16'h0000;
      drive_status_word_ff[HSH_ST_TARGET_BIT] <= target_ff; // [RULE17]
      drive_status_word_ff[HSH_ST_ATTAINED_BIT] <= attained_ff; // [RULE18]
      drive_status_word_ff[HSH_ST_ERR_BIT] <= err_ff; // [RULE19]
      drive_status_word_ff[HSH_ST_END_BIT] <=
        (home_ff == HSH_DONE) && standstill; // [RULE19]
      drive_status_word_ff[HSH_ST_REFOK_BIT] <= ref_ok_ff; // [RULE20]
    end
  end

  // Register read mux
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= 16'h0000;
    end else if (ce) begin
      if (reg_addr == HSH_ADDR_METHOD) begin
        reg_rdata_ff <= homing_method_select_ff;
      end else if (reg_addr == HSH_ADDR_STATUS) begin
        reg_rdata_ff <= drive_status_word_ff;
      end else if (reg_addr == HSH_ADDR_HOMEPOS_LO) begin
        reg_rdata_ff <= home_pos_ff[15:0];
      end else if (reg_addr == HSH_ADDR_HOMEPOS_HI) begin
        reg_rdata_ff <= home_pos_ff[31:16];
      end else if (reg_addr == HSH_ADDR_POL) begin
        reg_rdata_ff <= {10'h000, home_switch_polarity_ff,
                         positive_limit_polarity_ff,
                         negative_limit_polarity_ff};
      end else begin
        reg_rdata_ff <= 16'h0000;
      end
    end
  end
endmodule : hsh_homing

// file: inc/hsh_pkg.sv
package hsh_pkg;
  // Register offset of the homing method code (parameter address)
  localparam logic [15:0] HSH_ADDR_METHOD = 16'h1b18;
  localparam logic [15:0] HSH_ADDR_STATUS = 16'h1b1a;
  localparam logic [15:0] HSH_ADDR_CTRL = 16'h1b1c;
  localparam logic [15:0] HSH_ADDR_HOMEPOS_LO = 16'h1b1e;
  localparam logic [15:0] HSH_ADDR_HOMEPOS_HI = 16'h1b20;
  localparam logic [15:0] HSH_ADDR_POL = 16'h1b22;
  localparam logic [15:0] HSH_METHOD_RST = 16'h0012;
  // Control and status word bit positions
  localparam int HSH_CTRL_HOME_BIT = 4;
  localparam int HSH_ST_TARGET_BIT = 10;
  localparam int HSH_ST_ATTAINED_BIT = 12;
  localparam int HSH_ST_ERR_BIT = 13;
  localparam int HSH_ST_END_BIT = 14;
  localparam int HSH_ST_REFOK_BIT = 15;
  // Method code ranges
  localparam logic [7:0] HSH_M_IDX_LO = 8'h01;
  localparam logic [7:0] HSH_M_IDX_HI = 8'h0e;
  localparam logic [7:0] HSH_M_NEGATIVE_LIMIT_SWITCH = 8'h11;
  localparam logic [7:0] HSH_M_POSITIVE_LIMIT_SWITCH = 8'h12;
  localparam logic [7:0] HSH_M_REF_LO = 8'h17;
  localparam logic [7:0] HSH_M_REF_HI = 8'h1e;
  localparam logic [7:0] HSH_M_IDXNEG = 8'h1f;
  localparam logic [7:0] HSH_M_SETDIM = 8'h20;
  // Polarity codes: 0 inactive, 1 active low, 2 active high
  localparam logic [1:0] HSH_POL_OFF = 2'h0;
  localparam logic [1:0] HSH_POL_NC = 2'h1;
  localparam logic [1:0] HSH_POL_NO = 2'h2;
  localparam logic [1:0] HSH_POL_RST_LIM = 2'h1;
  localparam logic [1:0] HSH_POL_RST_REF = 2'h1;
  localparam int HSH_NSETS = 16;
  localparam logic [3:0] HSH_SEQ_HOME = 4'h0;
  // Transition conditions of a data set
  localparam logic [1:0] HSH_TC_DIRECT = 2'h0;
  localparam logic [1:0] HSH_TC_BLEND = 2'h1;
  localparam logic [1:0] HSH_TC_LEVEL = 2'h2;
  localparam logic [1:0] HSH_TC_EDGE = 2'h3;

  // One data set descriptor as held in the set memory
  typedef struct packed {
    logic [1:0] cond;
    logic [3:0] next;
    logic last;
    logic homing;
    logic [7:0] wait_ticks;
  } hsh_set_t;

  // Register write port bundle
  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [15:0] data;
  } hsh_wr_t;

  typedef enum logic [5:0] {
    HSH_IDLE = 6'b000001,
    HSH_SEARCH = 6'b000010,
    HSH_APPROACH = 6'b000100,
    HSH_DONE = 6'b001000,
    HSH_FAIL = 6'b010000,
    HSH_SETDIM = 6'b100000
  } hsh_home_t;

  typedef enum logic [3:0] {
    HSH_S_WAITSTART = 4'b0001,
    HSH_S_RUN = 4'b0010,
    HSH_S_DELAY = 4'b0100,
    HSH_S_TRANS = 4'b1000
  } hsh_seq_t;
endpackage : hsh_pkg

// file: logic/hsh_set_mem.sv
`timescale 1ns/10ps
// Data set table; read data comes out of a register
module hsh_set_mem
  import hsh_pkg::*;
(
  input wire logic clk,
  input wire logic ce,
  input wire logic wr,
  input wire logic [3:0] waddr,
  input wire hsh_set_t wdata,
  input wire logic [3:0] raddr,
  output hsh_set_t rdata
);
  hsh_set_t mem [HSH_NSETS];

  // Write port, no reset: contents are loaded by software
  always_ff @(posedge clk) begin
    if (ce && wr) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read
  always_ff @(posedge clk) begin
    if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule : hsh_set_mem

// file: verif/hsh_homing_checker.sv
`timescale 1ns/10ps
// Port-level watcher for the homing and sequence block
module hsh_homing_checker
  import hsh_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire hsh_wr_t reg_wr,
  input wire logic fieldbus_mode,
  input wire logic sequence_start_request,
  input wire logic standstill,
  input wire logic mode_change_req,
  input wire logic [15:0] drive_status_word_ff,
  input wire logic move_start_ff,
  input wire logic home_move_ff,
  input wire logic pos_load_ff,
  input wire logic mode_change_ok_ff,
  input wire logic x_end_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Short alias keeps the status properties readable
  wire logic [15:0] sw = drive_status_word_ff;

  property p_start_clr;
    $rose(move_start_ff) |-> !x_end_ff;
  endproperty
  a_start_clr: assert property (p_start_clr)
    else $error("done flag high as a set starts");
  property p_run_low;
    move_start_ff |=> !x_end_ff [*2];
  endproperty
  a_run_low: assert property (p_run_low)
    else $error("done flag rose right after a set start");
  property p_done_req;
    $rose(x_end_ff) |-> !$past(sequence_start_request);
  endproperty
  a_done_req: assert property (p_done_req)
    else $error("done flag rose while start request high");
  property p_done_still;
    $rose(x_end_ff) |-> $past(standstill);
  endproperty
  a_done_still: assert property (p_done_still)
    else $error("done flag rose with motor moving");
  property p_fb_only;
    $rose(home_move_ff) |-> $past(fieldbus_mode);
  endproperty
  a_fb_only: assert property (p_fb_only)
    else $error("homing started outside fieldbus mode");
  property p_ctrl_start;
    $rose(home_move_ff) |-> $past(reg_wr.wr && reg_wr.data[4] &&
      reg_wr.addr == HSH_ADDR_CTRL);
  endproperty
  a_ctrl_start: assert property (p_ctrl_start)
    else $error("homing motion without control bit write");
  property p_attained;
    sw[12] |-> sw[15] && sw[10] && !sw[13];
  endproperty
  a_attained: assert property (p_attained)
    else $error("attained bit with inconsistent status");
  property p_end_fin;
    sw[14] |-> sw[10];
  endproperty
  a_end_fin: assert property (p_end_fin)
    else $error("homing end bit without finished bit");
  property p_no_mode;
    home_move_ff |-> !mode_change_ok_ff;
  endproperty
  a_no_mode: assert property (p_no_mode)
    else $error("mode change granted during homing");
  property p_ok_req;
    mode_change_ok_ff |-> $past(mode_change_req);
  endproperty
  a_ok_req: assert property (p_ok_req)
    else $error("mode change granted without request");

  c_seq_done: cover property ($rose(x_end_ff));
  c_pos_load: cover property (pos_load_ff);
  c_home_go: cover property ($rose(home_move_ff));
endmodule : hsh_homing_checker

bind hsh_homing hsh_homing_checker u_chk (.clk, .rst, .reg_wr,
  .fieldbus_mode, .sequence_start_request, .standstill, .mode_change_req,
  .drive_status_word_ff, .move_start_ff, .home_move_ff, .pos_load_ff,
  .mode_change_ok_ff, .x_end_ff);

// file: verif/hsh_master_model.sv
`timescale 1ns/10ps
// Stand-in for the fieldbus master and the motion core behind it
module hsh_master_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic slow,
  input wire logic move_start_ff,
  input wire logic x_end_ff,
  output logic sequence_start_request,
  output logic motion_done,
  output logic standstill
);
  int cnt_ff;
  logic busy_ff;
  // Falling-edge drive keeps clear of the design's sampling edge
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      sequence_start_request <= 1'h0;
      motion_done <= 1'h0;
      standstill <= 1'h1;
      busy_ff <= 1'h0;
      cnt_ff <= 0;
    end else begin
      motion_done <= 1'h0;
      if (go && !sequence_start_request)
        sequence_start_request <= 1'h1;
      else if (move_start_ff && !x_end_ff)
        sequence_start_request <= 1'h0;
      // Slow moves outlast several controller cycles
      if (move_start_ff) begin
        busy_ff <= 1'h1;
        standstill <= 1'h0;
        cnt_ff <= slow ? 12 : 1;
      end else if (busy_ff && cnt_ff > 0) begin
        cnt_ff <= cnt_ff - 1;
      end else if (busy_ff) begin
        motion_done <= 1'h1;
        standstill <= 1'h1;
        busy_ff <= 1'h0;
      end
    end
  end
endmodule : hsh_master_model

// file: verif/testbench.sv
`timescale 1ns/10ps
// Drives on the falling edge; a monitor checks results against notes
module testbench
  import hsh_pkg::*;
;
  logic clk = 0, rst = 1, fieldbus_mode = 0, power_enable = 0, go = 0;
  logic slow = 0, set_wr = 0, halt = 0, dist_reached = 0, rd_flag = 0;
  logic positive_limit_switch = 1, mode_change_req = 0, rd_due = 0;
  logic [15:0] reg_addr = HSH_ADDR_METHOD, lo, hi;
  logic [3:0] starting_set_number = 4'h0, set_waddr = 4'h0;
  logic [31:0] setdim_value = 32'h0, sd;
  hsh_wr_t reg_wr = '0;
  hsh_set_t set_wdata = '0;
  logic [15:0] reg_rdata_ff, drive_status_word_ff, rq[$], rm[$];
  logic [3:0] move_set_ff, sq[$];
  logic [31:0] pos_load_value_ff, pq[$];
  logic sequence_start_request, motion_done, standstill, move_start_ff;
  logic home_dir_pos_ff, home_move_ff, pos_load_ff, mode_change_ok_ff;
  logic x_end_ff;
  integer fails = 0, checks_done = 0, cyc = 0, seed = 82, n;
  // Direct, blended, delayed, then last set looping back to set 1
  hsh_set_t tbl [4] = '{
    '{HSH_TC_DIRECT, 4'h1, 1'h0, 1'h0, 8'h00},
    '{HSH_TC_BLEND, 4'h2, 1'h0, 1'h0, 8'h00},
    '{HSH_TC_DIRECT, 4'h3, 1'h0, 1'h0, 8'h04},
    '{HSH_TC_DIRECT, 4'h1, 1'h1, 1'h0, 8'h00}};

  hsh_homing dut (.clk, .rst, .ce(1'h1), .reg_wr, .reg_addr,
    .reg_rdata_ff, .fieldbus_mode, .power_enable, .sequence_start_request,
    .starting_set_number, .set_wr, .set_waddr, .set_wdata, .motion_done,
    .standstill, .halt, .abort(1'h0), .dist_reached, .index_pulse(1'h0),
    .negative_limit_switch(1'h1), .positive_limit_switch,
    .home_switch(1'h1), .mode_change_req, .setdim_value,
    .drive_status_word_ff, .move_start_ff, .move_set_ff, .home_dir_pos_ff,
    .home_move_ff, .pos_load_ff, .pos_load_value_ff, .mode_change_ok_ff,
    .x_end_ff);
  hsh_master_model u_master (.clk, .rst, .go, .slow, .move_start_ff,
    .x_end_ff, .sequence_start_request, .motion_done, .standstill);

  initial forever #4 clk = ~clk;

  task automatic tally_and_finish;
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Strobe spans one edge, then drops for a cycle
  task automatic wr(input logic [15:0] a, d);
    reg_wr <= '{1'h1, a, d};
    @(negedge clk);
    reg_wr <= '0;
    @(negedge clk);
  endtask : wr

  // Masked read; the monitor compares once the data is registered
  task automatic rd(input logic [15:0] a, m, e);
    reg_addr <= a;
    rq.push_back(e);
    rm.push_back(m);
    rd_flag <= 1'h1;
    @(negedge clk);
    rd_flag <= 1'h0;
    @(negedge clk);
  endtask : rd

  task automatic home(input logic [15:0] meth);
    wr(HSH_ADDR_METHOD, meth);
    wr(HSH_ADDR_CTRL, 16'h0010);
    wr(HSH_ADDR_CTRL, 16'h0000);
  endtask : home

  task automatic drain;
    n = 0;
    while ((pq.size() + sq.size()) != 0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("drained", pq.size() + sq.size(), 32'h0);
  endtask : drain

  always @(posedge clk) rd_due <= rd_flag;

  // Each pulse or read takes the oldest note off its queue
  always @(negedge clk) begin
    if (rd_due)
      chk("rdata", reg_rdata_ff & rm.pop_front(), rq.pop_front());
    if (pos_load_ff === 1'h1)
      chk("pos", pos_load_value_ff, pq.size() ? pq.pop_front() : 'x);
    if (move_start_ff === 1'h1)
      chk("set", move_set_ff, sq.size() ? sq.pop_front() : 'x);
  end

  // Ceiling far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      tally_and_finish;
    end
  end

  initial begin
    repeat (4) @(negedge clk);
    rst <= 1'h0;
    @(negedge clk);
    rd(HSH_ADDR_METHOD, 16'hffff, HSH_METHOD_RST);
    home(16'h0012);
    chk("home_move", home_move_ff, 32'h0);
    fieldbus_mode <= 1'h1;
    lo = 16'($random(seed));
    hi = 16'($random(seed));
    wr(HSH_ADDR_HOMEPOS_LO, lo);
    wr(HSH_ADDR_HOMEPOS_HI, hi);
    home(16'h0012);
    chk("dir", {home_move_ff, home_dir_pos_ff}, 32'h3);
    mode_change_req <= 1'h1;
    repeat (2) @(negedge clk);
    chk("mode_ok", mode_change_ok_ff, 32'h0);
    // Limit inputs idle high: active low by default
    positive_limit_switch <= 1'h0;
    repeat (3) @(negedge clk);
    positive_limit_switch <= 1'h1;
    dist_reached <= 1'h1;
    pq.push_back({hi, lo});
    repeat (3) @(negedge clk);
    dist_reached <= 1'h0;
    drain;
    repeat (3) @(negedge clk);
    rd(HSH_ADDR_STATUS, 16'hf400, 16'hd400);
    chk("mode_ok", mode_change_ok_ff, 32'h1);
    mode_change_req <= 1'h0;
    sd = $random(seed);
    setdim_value <= sd;
    pq.push_back(sd);
    home(16'h0020);
    chk("home_move", home_move_ff, 32'h0);
    drain;
    rd(HSH_ADDR_METHOD, 16'hffff, 16'h0020);
    rd(HSH_ADDR_STATUS, 16'h9000, 16'h9000);
    home(16'h000f);
    repeat (2) @(negedge clk);
    rd(HSH_ADDR_STATUS, 16'h2400, 16'h2400);
    home(16'h0011);
    chk("dir", {home_move_ff, home_dir_pos_ff}, 32'h2);
    halt <= 1'h1;
    repeat (3) @(negedge clk);
    halt <= 1'h0;
    rd(HSH_ADDR_STATUS, 16'h9400, 16'h0400);
    for (int i = 0; i < 4; i++) begin
      set_waddr <= i[3:0];
      set_wdata <= tbl[i];
      set_wr <= 1'h1;
      @(negedge clk);
    end
    set_wr <= 1'h0;
    power_enable <= 1'h1;
    @(negedge clk);
    // Second pass is slow and resumes at the last set's successor
    for (int r = 0; r < 2; r++) begin
      slow <= r[0];
      for (int s = r; s < 4; s++)
        sq.push_back(s[3:0]);
      go <= 1'h1;
      @(negedge clk);
      go <= 1'h0;
      n = 0;
      while (x_end_ff === 1'h1 && n < 50) begin
        @(negedge clk);
        n++;
      end
      while (x_end_ff !== 1'h1 && n < 500) begin
        @(negedge clk);
        n++;
      end
      chk("sets_left", sq.size(), 32'h0);
      repeat (10) @(negedge clk);
      chk("x_end", x_end_ff, 32'h1);
    end
    tally_and_finish;
  end
endmodule : testbench
